// *** include/sdfc_pkg.sv ***
// Package of offsets, fields, reset values, timing counts and enums for the filter control block
package sdfc_pkg;

  // Register byte offsets on the AXI4-Lite slave
  localparam logic [7:0] ADDR_ADC_MODE = 8'h00;
  localparam logic [7:0] ADDR_IF_MODE = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_DATA = 8'h0c;
  localparam logic [7:0] ADDR_CH_EN = 8'h10;
  localparam logic [7:0] ADDR_CH_SETUP = 8'h14;
  localparam logic [7:0] ADDR_SETUP0 = 8'h20;
  localparam logic [7:0] ADDR_DATA_STAT = 8'h30;

  // Converter mode register fields
  localparam int MODE_SETTLED_BIT = 13;
  localparam int MODE_SEL_LSB = 4;
  localparam logic [15:0] ADC_MODE_RST = 16'h2000;

  // Interface mode register fields
  localparam int IF_APPEND_BIT = 6;
  localparam int IF_CONTREAD_BIT = 7;
  localparam logic [15:0] IF_MODE_RST = 16'h0000;

  // Setup filter configuration fields
  localparam int FILT_MAP_BIT = 15;
  localparam int FILT_ENH_EN_BIT = 11;
  localparam int FILT_ENH_LSB = 8;
  localparam int FILT_ORDER_LSB = 5;
  localparam logic [1:0] ORDER_SINC3 = 2'h3;
  localparam logic [15:0] FILT_RST = 16'h0000;

  // Channel enable and channel-to-setup map reset values
  localparam logic [3:0] CH_EN_RST = 4'h1;
  localparam logic [7:0] CH_SETUP_RST = 8'h00;

  // Status register fields
  localparam int STAT_RDY_BIT = 7;

  // Timing: master clock, modulator and sinc5 output rate
  localparam int CLK_HZ = 200_000_000;
  localparam int MCLK_HZ = 2_000_000;
  localparam int MOD_PER_MCLK = 2;
  localparam int MOD_HZ = MCLK_HZ / MOD_PER_MCLK;
  localparam int MOD_CYC = (CLK_HZ / MCLK_HZ) * MOD_PER_MCLK;
  localparam int SINC5_DEC = 32;
  localparam int SINC5_EXTRA = 4;
  localparam int SINGLE_CYC_DIV = 12;
  localparam int SINC3_SETTLE_PER = 3;

  // Enhanced 50/60 Hz post-filter settling times in microseconds
  localparam int ENH_US_0 = 36670;
  localparam int ENH_US_1 = 40000;
  localparam int ENH_US_2 = 50000;
  localparam int ENH_US_3 = 60000;

  // Converter operating modes
  typedef enum logic [2:0] {
    MODE_CONT = 3'h0,
    MODE_SINGLE = 3'h1,
    MODE_STANDBY = 3'h2,
    MODE_PDOWN = 3'h3,
    MODE_INT_ZS = 3'h4,
    MODE_INT_FS = 3'h5,
    MODE_SYS_ZS = 3'h6,
    MODE_SYS_FS = 3'h7
  } sdfc_mode_t;

  // Sequencer states
  typedef enum logic {
    ST_IDLE = 1'b0,
    ST_CONV = 1'b1
  } sdfc_state_t;

endpackage

// *** logic/sdfc_accum.sv ***
// Boxcar accumulator that averages modulator samples over one output window
module sdfc_accum #(
  parameter int SW = 24,
  parameter int AW = 48
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Control
  input wire logic clr,
  input wire logic add,
  input wire logic dump,
  input wire logic [4:0] shift,
  // Samples and average
  input wire logic [SW-1:0] sample,
  output logic [SW-1:0] avg
);

  logic [AW-1:0] sum_q;
  logic [AW-1:0] sum_d;
  logic [AW-1:0] total;

  // Sign-extended running sum including the sample of this tick
  assign total = sum_q + {{(AW-SW){sample[SW-1]}}, sample};
  // Shift stands in for a divider; window lengths that are not powers of two read high, by up to nearly twice
  assign avg = SW'($signed(total) >>> shift);
  assign sum_d = (clr || dump) ? '0 : (add ? total : sum_q);

  // Sum register, emptied at each dump or channel switch
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sum_q <= '0;
    end else begin
      sum_q <= sum_d;
    end
  end

endmodule

// *** logic/sdfc_ctrl.sv ***
// Filter selection, conversion timing, channel sequencer and result registers
//
// The placing of the registers and the AXI4-Lite interface to the registers were decided locally.
module sdfc_ctrl #(
  parameter int NCH = 4,
  parameter int NSETUP = 4,
  parameter int MOD_CYC = sdfc_pkg::MOD_CYC
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address and data
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Modulator side
  output logic mod_strobe,
  input wire logic [23:0] mod_sample,
  // Serial interface pins
  input wire logic cs_n,
  output logic rdy_n
);

  localparam int TW = 23;

  // Sinc1 averaging length in sinc5 outputs for each rate code
  function automatic logic [14:0] odr_div(input logic [4:0] code);
    logic [14:0] d;
    d = 15'h0001;
    unique case (code)
      5'h00: d = 15'h0001;
      5'h01: d = 15'h0002;
      5'h02: d = 15'h0004;
      5'h03: d = 15'h0008;
      5'h04: d = 15'h000c;
      5'h05: d = 15'h0020;
      5'h06: d = 15'h0040;
      5'h07: d = 15'h007d;
      5'h08: d = 15'h00fa;
      5'h09: d = 15'h0271;
      5'h0a: d = 15'h04e2;
      5'h0b: d = 15'h0c35;
      5'h0c: d = 15'h186a;
      5'h0d: d = 15'h3d09;
      default: d = 15'h61a8;
    endcase
    return d;
  endfunction

  // Next enabled channel above cur, wrapping to the lowest
  function automatic logic [3:0] next_ch(input logic [NCH-1:0] en, input logic [3:0] cur);
    logic [3:0] n;
    logic hit;
    n = cur;
    hit = 1'b0;
    // Descending scan leaves the lowest enabled channel above cur
    for (int i = NCH - 1; i >= 0; i--) begin
      if (en[i] && 4'(i) > cur) begin
        n = 4'(i);
        hit = 1'b1;
      end
    end
    if (!hit) begin
      for (int i = NCH - 1; i >= 0; i--) begin
        if (en[i]) begin
          n = 4'(i);
        end
      end
    end
    return n;
  endfunction

  // Floor of log2, used as the averaging shift
  function automatic logic [4:0] log2f(input logic [TW-1:0] v);
    logic [4:0] r;
    r = 5'h00;
    for (int i = 0; i < TW; i++) begin
      if (v[i]) begin
        r = 5'(i);
      end
    end
    return r;
  endfunction

  // Enhanced filter period in modulator ticks
  function automatic logic [TW-1:0] enh_ticks(input logic [1:0] sel);
    int us;
    us = sdfc_pkg::ENH_US_0;
    unique case (sel)
      2'h0: us = sdfc_pkg::ENH_US_0;
      2'h1: us = sdfc_pkg::ENH_US_1;
      2'h2: us = sdfc_pkg::ENH_US_2;
      2'h3: us = sdfc_pkg::ENH_US_3;
    endcase
    return TW'(us * (sdfc_pkg::MOD_HZ / 1_000_000));
  endfunction

  // Registers
  logic [15:0] adc_mode_q;
  logic [15:0] if_mode_q;
  logic [NCH-1:0] ch_en_q;
  logic [2*NCH-1:0] ch_setup_q;
  logic [15:0] filt_q [NSETUP];
  logic [23:0] data_q;
  logic [3:0] stat_ch_q;
  logic rdy_flag_n_q;

  // Sequencer state
  sdfc_pkg::sdfc_state_t state_q;
  logic [3:0] ch_q;
  logic [15:0] cfg_q;
  logic [TW-1:0] cnt_q;
  logic first_q;
  logic restart_q;
  logic [7:0] tick_cnt_q;
  logic cs_meta_q;
  logic cs_sync_q;

  // Bus state
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic rd_data_q;

  // Modulator tick, divided from aclk; a larger MOD_CYC scales every rate down
  wire mod_tick = (tick_cnt_q == 8'(MOD_CYC - 1));
  assign mod_strobe = mod_tick;

  // Operating mode decode: only continuous conversion is sequenced here
  wire [2:0] mode_w = adc_mode_q[sdfc_pkg::MODE_SEL_LSB +: 3];
  wire run_w = (mode_w == 3'(sdfc_pkg::MODE_CONT)) && (|ch_en_q);
  wire multi_w = |(ch_en_q & (ch_en_q - NCH'(1)));
  wire [3:0] first_ch_w = next_ch(ch_en_q, 4'hf);

  // Setup lookup for the channel about to start
  function automatic logic [15:0] cfg_of(input logic [3:0] ch);
    logic [1:0] s;
    s = ch_setup_q[2*ch[1:0] +: 2];
    return filt_q[s];
  endfunction

  // Filter timing from the latched setup
  wire map_w = cfg_q[sdfc_pkg::FILT_MAP_BIT];
  wire sinc3_w = map_w || (cfg_q[sdfc_pkg::FILT_ORDER_LSB +: 2] == sdfc_pkg::ORDER_SINC3);
  wire enh_w = !sinc3_w && cfg_q[sdfc_pkg::FILT_ENH_EN_BIT];
  wire [14:0] map_dec_w = (cfg_q[14:0] == 15'h0000) ? 15'h0001 : cfg_q[14:0];
  wire [14:0] dec_w = map_w ? map_dec_w : odr_div(cfg_q[4:0]);
  wire fast_settle_w = !sinc3_w && (dec_w >= 15'(sdfc_pkg::SINGLE_CYC_DIV));
  wire [TW-1:0] per_w = enh_w ? enh_ticks(cfg_q[sdfc_pkg::FILT_ENH_LSB +: 2])
                              : TW'(dec_w) * TW'(sdfc_pkg::SINC5_DEC);
  wire [TW-1:0] settle_sinc5_w = fast_settle_w ? per_w
                                 : per_w + TW'(sdfc_pkg::SINC5_DEC * sdfc_pkg::SINC5_EXTRA);
  wire [TW-1:0] settle_w = enh_w ? per_w
                           : (sinc3_w ? per_w * TW'(sdfc_pkg::SINC3_SETTLE_PER)
                                      : settle_sinc5_w);
  wire settled_en_w = adc_mode_q[sdfc_pkg::MODE_SETTLED_BIT] && !multi_w && !fast_settle_w;
  // First result after a switch and every settled-only result take the full settling time
  wire [TW-1:0] target_w = (first_q || settled_en_w) ? settle_w : per_w;
  wire done_w = (state_q == sdfc_pkg::ST_CONV) && mod_tick && !restart_q && run_w
                && (cnt_q == target_w - TW'(1));
  wire clr_w = (state_q == sdfc_pkg::ST_IDLE) || (done_w && multi_w);

  // Averaging filter core
  logic [23:0] avg_w;
  sdfc_accum #(.SW(24), .AW(48)) u_accum (
    .aclk(aclk),
    .aresetn(aresetn),
    .clr(clr_w),
    .add(mod_tick && (state_q == sdfc_pkg::ST_CONV)),
    .dump(done_w),
    .shift(log2f(target_w)),
    .sample(mod_sample),
    .avg(avg_w)
  );

  // Bus decode
  wire wr_go = s_axi_awvalid && s_axi_wvalid && !bvalid_q;
  wire rd_go = s_axi_arvalid && !rvalid_q;
  assign s_axi_awready = wr_go;
  assign s_axi_wready = wr_go;
  assign s_axi_arready = rd_go;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  wire [7:0] wa = {s_axi_awaddr[7:2], 2'b00};
  wire [7:0] ra = {s_axi_araddr[7:2], 2'b00};
  wire wr_setup = (wa[7:4] == sdfc_pkg::ADDR_SETUP0[7:4]);
  wire wr_ok = (wa == sdfc_pkg::ADDR_ADC_MODE) || (wa == sdfc_pkg::ADDR_IF_MODE)
               || (wa == sdfc_pkg::ADDR_CH_EN) || (wa == sdfc_pkg::ADDR_CH_SETUP) || wr_setup;
  wire [31:0] wmask = {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
                       {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};

  // Byte-lane merge of a write into a 16-bit register
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
                                          input logic [31:0] m);
    return (old & ~m[15:0]) | (wd[15:0] & m[15:0]);
  endfunction

  // Status byte: ready flag and the channel of the held result
  wire [7:0] status_w = {rdy_flag_n_q, 3'b000, stat_ch_q};
  wire rd_is_data = (ra == sdfc_pkg::ADDR_DATA) || (ra == sdfc_pkg::ADDR_DATA_STAT);
  wire append_w = if_mode_q[sdfc_pkg::IF_APPEND_BIT];
  wire [31:0] data_word_w = (append_w && ra == sdfc_pkg::ADDR_DATA_STAT)
                            ? {status_w, data_q} : {8'h00, data_q};
  wire [1:0] setup_idx = ra[3:2];
  wire rd_setup = (ra[7:4] == sdfc_pkg::ADDR_SETUP0[7:4]);
  // Read decode looks at the read address only; the write address may be stale
  wire rd_ok = (ra == sdfc_pkg::ADDR_ADC_MODE) || (ra == sdfc_pkg::ADDR_IF_MODE)
               || (ra == sdfc_pkg::ADDR_CH_EN) || (ra == sdfc_pkg::ADDR_CH_SETUP) || rd_setup
               || (ra == sdfc_pkg::ADDR_STATUS) || rd_is_data;
  wire [31:0] rd_mux =
    (ra == sdfc_pkg::ADDR_ADC_MODE) ? {16'h0000, adc_mode_q} :
    (ra == sdfc_pkg::ADDR_IF_MODE) ? {16'h0000, if_mode_q} :
    (ra == sdfc_pkg::ADDR_STATUS) ? {24'h000000, status_w} :
    rd_is_data ? data_word_w :
    (ra == sdfc_pkg::ADDR_CH_EN) ? {28'h0000000, ch_en_q} :
    (ra == sdfc_pkg::ADDR_CH_SETUP) ? {24'h000000, ch_setup_q} :
    rd_setup ? {16'h0000, filt_q[setup_idx[1:0]]} : 32'h00000000;

  // A data access runs from address acceptance until the answer is taken
  wire data_busy = (rd_go && rd_is_data) || (rvalid_q && rd_data_q);
  wire take_w = done_w && !data_busy;

  // Write channel and register writes; any write to a writable address restarts the sequence
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      adc_mode_q <= sdfc_pkg::ADC_MODE_RST;
      if_mode_q <= sdfc_pkg::IF_MODE_RST;
      ch_en_q <= NCH'(sdfc_pkg::CH_EN_RST);
      ch_setup_q <= (2*NCH)'(sdfc_pkg::CH_SETUP_RST);
      for (int i = 0; i < NSETUP; i++) begin
        filt_q[i] <= sdfc_pkg::FILT_RST;
      end
      bvalid_q <= 1'b0;
      bresp_q <= 2'b00;
      restart_q <= 1'b0;
    end else begin
      restart_q <= wr_go && wr_ok;
      if (wr_go) begin
        bvalid_q <= 1'b1;
        bresp_q <= wr_ok ? 2'b00 : 2'b10;
        if (wa == sdfc_pkg::ADDR_ADC_MODE) begin
          adc_mode_q <= merge16(adc_mode_q, s_axi_wdata, wmask);
        end
        if (wa == sdfc_pkg::ADDR_IF_MODE) begin
          if_mode_q <= merge16(if_mode_q, s_axi_wdata, wmask);
        end
        if (wa == sdfc_pkg::ADDR_CH_EN && s_axi_wstrb[0]) begin
          ch_en_q <= s_axi_wdata[NCH-1:0];
        end
        if (wa == sdfc_pkg::ADDR_CH_SETUP && s_axi_wstrb[0]) begin
          ch_setup_q <= s_axi_wdata[2*NCH-1:0];
        end
        if (wr_setup) begin
          filt_q[wa[3:2]] <= merge16(filt_q[wa[3:2]], s_axi_wdata, wmask);
        end
      end else if (s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // Read channel: answer one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= 2'b00;
      rd_data_q <= 1'b0;
    end else if (rd_go) begin
      rvalid_q <= 1'b1;
      rdata_q <= rd_mux;
      rresp_q <= rd_ok ? 2'b00 : 2'b10;
      rd_data_q <= rd_is_data;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
      rd_data_q <= 1'b0;
    end
  end

  // Modulator tick divider
  always_ff @(posedge aclk) begin
    if (!aresetn || mod_tick) begin
      tick_cnt_q <= 8'h00;
    end else begin
      tick_cnt_q <= tick_cnt_q + 8'h01;
    end
  end

  // Channel sequencer and window counter
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= sdfc_pkg::ST_IDLE;
      ch_q <= 4'h0;
      cfg_q <= sdfc_pkg::FILT_RST;
      cnt_q <= '0;
      first_q <= 1'b1;
    end else begin
      unique case (state_q)
        sdfc_pkg::ST_IDLE: begin
          cnt_q <= '0;
          first_q <= 1'b1;
          if (run_w && !restart_q) begin
            state_q <= sdfc_pkg::ST_CONV;
            ch_q <= first_ch_w;
            cfg_q <= cfg_of(first_ch_w);
          end
        end
        sdfc_pkg::ST_CONV: begin
          if (restart_q || !run_w) begin
            state_q <= sdfc_pkg::ST_IDLE;
          end else if (done_w) begin
            cnt_q <= '0;
            first_q <= multi_w;
            if (multi_w) begin
              ch_q <= next_ch(ch_en_q, ch_q);
              cfg_q <= cfg_of(next_ch(ch_en_q, ch_q));
            end
          end else if (mod_tick) begin
            cnt_q <= cnt_q + TW'(1);
          end
        end
      endcase
    end
  end

  // Result register and ready flag; a completion that falls inside a data access is dropped
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      data_q <= 24'h000000;
      stat_ch_q <= 4'h0;
      rdy_flag_n_q <= 1'b1;
    end else if (take_w) begin
      data_q <= avg_w;
      stat_ch_q <= ch_q;
      rdy_flag_n_q <= 1'b0;
    end else if (rd_go && rd_is_data) begin
      rdy_flag_n_q <= 1'b1;
    end
  end

  // Chip select synchroniser; the pin is asynchronous to aclk
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cs_meta_q <= 1'b1;
      cs_sync_q <= 1'b1;
    end else begin
      cs_meta_q <= cs_n;
      cs_sync_q <= cs_meta_q;
    end
  end

  // Ready pin shows the flag only while the part is selected
  assign rdy_n = rdy_flag_n_q | cs_sync_q;

endmodule

// *** verification/sdfc_ctrl_chk.sv ***
// Concurrent checks on the filter control block ports
module sdfc_ctrl_chk #(
  parameter int MOD_CYC = 4
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Register bus
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Modulator and pins
  input wire logic mod_strobe,
  input wire logic cs_n,
  input wire logic rdy_n
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [15:0] gap_q;
  logic seen_q;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Cycles since the last modulator tick; seen_q masks the first tick after reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gap_q <= 16'h0;
      seen_q <= 1'b0;
    end else if (mod_strobe) begin
      gap_q <= 16'h0;
      seen_q <= 1'b1;
    end else begin
      gap_q <= gap_q + 16'h1;
    end
  end

  // Handshake steps of the bus
  sequence s_rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence s_wr_take;
    s_axi_awvalid && s_axi_awready;
  endsequence

  a_read_answer: assert property (s_rd_take |=> s_axi_rvalid)
    else $error("read answer missing");
  a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  a_ar_gate: assert property (s_axi_arready == (s_axi_arvalid && !s_axi_rvalid))
    else $error("arready wrong");
  a_write_answer: assert property (s_wr_take |=> s_axi_bvalid)
    else $error("write answer missing");
  a_aw_gate: assert property (s_axi_awready == (s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid))
    else $error("awready wrong");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped early");
  a_ro_refuse: assert property (s_axi_awvalid && s_axi_awready && s_axi_awaddr == sdfc_pkg::ADDR_STATUS
    |=> s_axi_bresp == 2'h2) else $error("status write accepted");
  a_tick_period: assert property (mod_strobe && seen_q |-> gap_q == MOD_CYC - 1)
    else $error("modulator tick spacing wrong");
  a_tick_late: assert property (seen_q |-> gap_q < MOD_CYC)
    else $error("modulator tick missing");
  a_rdy_deselect: assert property (cs_n [*3] |-> rdy_n)
    else $error("ready pin low while deselected");
endmodule

bind sdfc_ctrl sdfc_ctrl_chk #(.MOD_CYC(MOD_CYC)) u_chk (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .mod_strobe(mod_strobe), .cs_n(cs_n), .rdy_n(rdy_n));

// *** verification/sdfc_mod_model.sv ***
// Modulator model feeding samples to the filter control block
module sdfc_mod_model (
  // Tick and requested level
  input wire logic mod_strobe,
  input wire logic [23:0] level,
  // Sample to the block
  output logic [23:0] mod_sample
);
  timeunit 1ns;
  timeprecision 100ps;
  // Inverse off the tick so a sample taken at the wrong cycle shows in the result
  assign mod_sample = mod_strobe ? level : ~level;
endmodule

// *** verification/sdfc_ctrl_test.sv ***
// Self-checking bench for the filter control block
module sdfc_ctrl_test;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int MC = 4;
  localparam int TOL = MC + 3;
  localparam logic [7:0] RA [7] = '{sdfc_pkg::ADDR_ADC_MODE, sdfc_pkg::ADDR_IF_MODE,
    sdfc_pkg::ADDR_CH_EN, sdfc_pkg::ADDR_CH_SETUP, sdfc_pkg::ADDR_SETUP0,
    sdfc_pkg::ADDR_STATUS, sdfc_pkg::ADDR_DATA};
  localparam logic [31:0] RV [7] = '{{16'h0, sdfc_pkg::ADC_MODE_RST}, {16'h0, sdfc_pkg::IF_MODE_RST},
    {28'h0, sdfc_pkg::CH_EN_RST}, {24'h0, sdfc_pkg::CH_SETUP_RST}, {16'h0, sdfc_pkg::FILT_RST},
    32'h80, 32'h0};
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, cs_n;
  logic awready, wready, bvalid, arready, rvalid, mod_strobe, rdy_n, rdy_q;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic [23:0] level, mod_sample;
  int fail_count, cmp_count, cyc, falls, tfall, tprev;

  sdfc_ctrl #(.MOD_CYC(MC)) dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .mod_strobe(mod_strobe), .mod_sample(mod_sample), .cs_n(cs_n),
    .rdy_n(rdy_n));
  sdfc_mod_model u_mod (.mod_strobe(mod_strobe), .level(level), .mod_sample(mod_sample));

  // 200 MHz clock
  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  // Stamps each falling edge of the ready pin
  always @(posedge aclk) begin
    cyc++;
    if (rdy_q === 1'b1 && rdy_n === 1'b0) begin
      falls++;
      tfall = cyc;
    end
    rdy_q = rdy_n;
  end

  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask

  // One write; the block restarts its sequence at the answer to a writable address, so the gap clock restarts too
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin @(posedge aclk); n++; end while (awready !== 1'b1 && n < 99);
    chk("wready", wready, 1'b1);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    do begin @(posedge aclk); n++; end while (bvalid !== 1'b1 && n < 99);
    bready <= 1'b0;
    tprev = cyc;
    chk("bresp", bresp, er);
  endtask

  // One read; hold delays rready to keep the answer pending
  task automatic rd(input logic [7:0] a, input int hold, output logic [31:0] d,
                    output logic [1:0] r);
    int n;
    n = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= (hold == 0);
    do begin @(posedge aclk); n++; end while (arready !== 1'b1 && n < 99);
    arvalid <= 1'b0;
    repeat (hold) @(posedge aclk);
    rready <= 1'b1;
    do begin @(posedge aclk); n++; end while (!(rvalid === 1'b1 && rready === 1'b1) && n < 9999);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  // Waits for a completion, checks its spacing in ticks, then reads it and checks its status
  task automatic step(input int et, input logic [3:0] ech);
    int f, n, g;
    logic [31:0] d;
    logic [1:0] r;
    f = falls;
    n = 0;
    while (falls == f && n < 30000) begin @(posedge aclk); n++; end
    g = tfall - tprev;
    chk("gap", g >= et * MC - TOL && g <= et * MC + TOL, 1'b1);
    tprev = tfall;
    rd(sdfc_pkg::ADDR_DATA_STAT, 0, d, r);
    chk("stat_rdy", d[31], 1'b0);
    chk("stat_ch", d[27:24], ech);
    repeat (4) @(posedge aclk);
    chk("pin_high", rdy_n, 1'b1);
  endtask

  task automatic t_reset;
    logic [31:0] d;
    logic [1:0] r;
    for (int i = 0; i < 7; i++) begin
      rd(RA[i], 0, d, r);
      chk("reset_value", d, RV[i]);
    end
    rd(8'h3c, 0, d, r);
    chk("unmapped", {r, d[29:0]}, 32'h80000000);
    wr(sdfc_pkg::ADDR_STATUS, 32'h0, 2'h2);
    wr(sdfc_pkg::ADDR_IF_MODE, 32'h40, 2'h0);
  endtask

  // Settled-only timing, sinc5 rate ladder, data hold, reread and discard
  task automatic t_sinc5;
    logic [31:0] d;
    logic [1:0] r;
    step(160, 4'h0);
    step(160, 4'h0);
    wr(sdfc_pkg::ADDR_ADC_MODE, 32'h0, 2'h0);
    step(160, 4'h0);
    step(32, 4'h0);
    wr(sdfc_pkg::ADDR_SETUP0, 32'h5, 2'h0);
    wr(sdfc_pkg::ADDR_ADC_MODE, 32'h2000, 2'h0);
    step(1024, 4'h0);
    step(1024, 4'h0);
    for (int i = 0; i < 2; i++) begin
      rd(sdfc_pkg::ADDR_DATA, 0, d, r);
      chk("data", d, 32'h012345);
    end
    level <= 24'h000777;
    rd(sdfc_pkg::ADDR_DATA, 5000, d, r);
    rd(sdfc_pkg::ADDR_DATA, 0, d, r);
    chk("discard", d, 32'h012345);
    step(2048, 4'h0);
    rd(sdfc_pkg::ADDR_DATA, 0, d, r);
    chk("data_new", d, 32'h000777);
  endtask

  task automatic t_sinc3;
    wr(sdfc_pkg::ADDR_SETUP0, 32'h60, 2'h0);
    wr(sdfc_pkg::ADDR_ADC_MODE, 32'h0, 2'h0);
    step(96, 4'h0);
    step(32, 4'h0);
    wr(sdfc_pkg::ADDR_ADC_MODE, 32'h2000, 2'h0);
    step(96, 4'h0);
    step(96, 4'h0);
    wr(sdfc_pkg::ADDR_SETUP0, 32'h8021, 2'h0);
    wr(sdfc_pkg::ADDR_ADC_MODE, 32'h0, 2'h0);
    step(3168, 4'h0);
    step(1056, 4'h0);
  endtask

  // Channels 0, 1 and 3 with channel 1 on its own sinc3 setup
  task automatic t_multi;
    int f;
    logic [31:0] d;
    logic [1:0] r;
    wr(sdfc_pkg::ADDR_ADC_MODE, 32'h2000, 2'h0);
    wr(sdfc_pkg::ADDR_SETUP0 + 8'h04, 32'h60, 2'h0);
    wr(sdfc_pkg::ADDR_SETUP0, 32'h0, 2'h0);
    wr(sdfc_pkg::ADDR_CH_SETUP, 32'h04, 2'h0);
    wr(sdfc_pkg::ADDR_CH_EN, 32'h0b, 2'h0);
    step(160, 4'h0);
    step(96, 4'h1);
    step(160, 4'h3);
    step(160, 4'h0);
    wr(sdfc_pkg::ADDR_ADC_MODE, 32'h20, 2'h0);
    f = falls;
    repeat (2000) @(posedge aclk);
    chk("standby", falls == f, 1'b1);
    wr(sdfc_pkg::ADDR_ADC_MODE, 32'h0, 2'h0);
    step(160, 4'h0);
    // Deselected: the channel 1 completion sets the flag but the pin stays high
    cs_n <= 1'b1;
    repeat (800) @(posedge aclk);
    chk("deselect_pin", rdy_n, 1'b1);
    rd(sdfc_pkg::ADDR_STATUS, 0, d, r);
    chk("deselect_flag", d[7], 1'b0);
    chk("deselect_ch", d[3:0], 4'h1);
  endtask

  task automatic end_of_test;
    $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Cuts a hang short well above the expected run of about 42500 cycles
  initial begin
    repeat (95000) @(posedge aclk);
    fail_count++;
    end_of_test;
  end

  // Reset for five cycles, then the scenarios
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h0;
    {awaddr, araddr, wdata} = 48'h0;
    wstrb = 4'hf;
    cs_n = 1'b1;
    rdy_q = 1'b1;
    level = 24'h012345;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset;
    cs_n <= 1'b0;
    t_sinc5;
    t_sinc3;
    t_multi;
    end_of_test;
  end
endmodule
